/* File: mgb_map.svh */
// Address map, field positions and reset values of the bus glue
`ifndef MGB_MAP_SVH
`define MGB_MAP_SVH

// ---------------------------------------------------------------
// Field positions within the upper address byte
// ---------------------------------------------------------------
`define MGB_HI_RAM_BIT   7          // A15 position inside the upper byte
`define MGB_HI_PAGE_MSB  7          // Top nibble of the upper byte
`define MGB_HI_PAGE_LSB  4
`define MGB_HI_DIR_MSB   6          // A14..A8, passed straight to the memory
`define MGB_HI_DIR_LSB   0

// ---------------------------------------------------------------
// Decode values
// ---------------------------------------------------------------
`define MGB_IO_PAGE      4'h7       // Port page 0x7000 to 0x7fff
`define MGB_RW_READ      1'b1       // Direction line level for a read

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MGB_RST_BYTE     8'h00
`define MGB_RST_ADDR     15'h0000
`define MGB_RST_INACT    1'b1       // Active-low strobes idle high
`define MGB_RST_OFF      1'b0

`endif

/* File: mgb_pkg.sv */
// Types shared by the bus glue
package mgb_pkg;

  // Processor pins after synchronisation
  typedef struct packed {
    logic       as;     // Address strobe
    logic       e;      // Bus phase strobe
    logic       rw;     // High for read, low for write
    logic [7:0] hi;     // Upper address byte A15..A8
    logic [7:0] ad;     // Shared address/data lines
  } mgb_cpu_s;

  // Memory-side strobes
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } mgb_mem_s;

endpackage : mgb_pkg

/* File: mgb_glue.sv */
// Glue between a multiplexed-bus processor, a byte-wide static RAM and two port latches
`timescale 1ns/1ps
`include "mgb_map.svh"

module mgb_glue
  import mgb_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Processor bus
  input  wire logic        AS,
  input  wire logic        E,
  input  wire logic        RW,
  input  wire logic [7:0]  A_HI,
  input  wire logic [7:0]  AD_I,
  output logic      [7:0]  AD_O,
  output logic             AD_OE,
  // Static RAM
  output logic      [14:0] RAM_A,
  input  wire logic [7:0]  RAM_DQ_I,
  output logic      [7:0]  RAM_DQ_O,
  output logic             RAM_DQ_OE,
  output logic             RAM_CE_N,
  output logic             RAM_OE_N,
  output logic             RAM_WE_N,
  // Port latches
  input  wire logic [7:0]  IN_PORT,
  output logic      [7:0]  OUT_PORT
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  mgb_cpu_s   cpu_s1_q;
  mgb_cpu_s   cpu_q;
  logic [7:0] ram_s1_q;
  logic [7:0] ram_q;
  logic [7:0] in_s1_q;
  logic [7:0] in_q;

  // Two flops on every outside level except RST; stage one feeds stage two only
  always_ff @(posedge CLK) begin
    if (RST) begin
      cpu_s1_q <= '0;
      cpu_q    <= '0;
      ram_s1_q <= `MGB_RST_BYTE;
      ram_q    <= `MGB_RST_BYTE;
      in_s1_q  <= `MGB_RST_BYTE;
      in_q     <= `MGB_RST_BYTE;
    end else begin
      cpu_s1_q <= '{as: AS, e: E, rw: RW, hi: A_HI, ad: AD_I};
      cpu_q    <= cpu_s1_q;
      ram_s1_q <= RAM_DQ_I;
      ram_q    <= ram_s1_q;
      in_s1_q  <= IN_PORT;
      in_q     <= in_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Decode and next values
  // ---------------------------------------------------------------
  logic [7:0]  addr_lo_q, addr_lo_d;
  logic [14:0] ram_a_q, ram_a_d;
  mgb_mem_s    mem_q, mem_d;
  logic [7:0]  ad_o_q, ad_o_d;
  logic        ad_oe_q, ad_oe_d;
  logic [7:0]  dq_o_q, dq_o_d;
  logic        dq_oe_q, dq_oe_d;
  logic [7:0]  out_q, out_d;
  logic        ram_en;
  logic        io_sel;
  logic        rd;

  always_comb begin
    rd        = (cpu_q.rw == `MGB_RW_READ);
    ram_en    = cpu_q.hi[`MGB_HI_RAM_BIT] & cpu_q.e;
    io_sel    = (cpu_q.hi[`MGB_HI_PAGE_MSB:`MGB_HI_PAGE_LSB] == `MGB_IO_PAGE) & cpu_q.e;
    addr_lo_d = cpu_q.as ? cpu_q.ad : addr_lo_q;
    ram_a_d   = {cpu_q.hi[`MGB_HI_DIR_MSB:`MGB_HI_DIR_LSB], addr_lo_q};
    mem_d.ce_n = ~ram_en;
    mem_d.oe_n = ~(ram_en & rd);
    mem_d.we_n = ~(ram_en & ~rd);
    // shared lines carry write data to the RAM
    dq_o_d    = cpu_q.ad;
    dq_oe_d   = ram_en & ~rd;
    // memory or input latch drives on reads
    ad_oe_d   = (ram_en | io_sel) & rd;
    ad_o_d    = ram_en ? ram_q : in_q;
    out_d     = (io_sel & ~rd) ? cpu_q.ad : out_q;
  end

  // Register every output and the address latch
  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_lo_q <= `MGB_RST_BYTE;
      ram_a_q   <= `MGB_RST_ADDR;
      mem_q     <= '{ce_n: `MGB_RST_INACT, oe_n: `MGB_RST_INACT, we_n: `MGB_RST_INACT};
      ad_o_q    <= `MGB_RST_BYTE;
      ad_oe_q   <= `MGB_RST_OFF;
      dq_o_q    <= `MGB_RST_BYTE;
      dq_oe_q   <= `MGB_RST_OFF;
      out_q     <= `MGB_RST_BYTE;
    end else begin
      addr_lo_q <= addr_lo_d;
      ram_a_q   <= ram_a_d;
      mem_q     <= mem_d;
      ad_o_q    <= ad_o_d;
      ad_oe_q   <= ad_oe_d;
      dq_o_q    <= dq_o_d;
      dq_oe_q   <= dq_oe_d;
      out_q     <= out_d;
    end
  end

  // Port drive
  assign RAM_A     = ram_a_q;
  assign RAM_CE_N  = mem_q.ce_n;
  assign RAM_OE_N  = mem_q.oe_n;
  assign RAM_WE_N  = mem_q.we_n;
  assign RAM_DQ_O  = dq_o_q;
  assign RAM_DQ_OE = dq_oe_q;
  assign AD_O      = ad_o_q;
  assign AD_OE     = ad_oe_q;
  assign OUT_PORT  = out_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_lat_capture;
    @(posedge CLK) disable iff (RST) cpu_q.as |=> addr_lo_q == $past(cpu_q.ad);
  endproperty
  a_lat_capture: assert property (p_lat_capture) else $error("Address latch missed strobe");

  property p_lat_hold;
    @(posedge CLK) disable iff (RST) !cpu_q.as |=> $stable(addr_lo_q);
  endproperty
  a_lat_hold: assert property (p_lat_hold) else $error("Address latch changed without strobe");

  property p_addr_join;
    @(posedge CLK) disable iff (RST) cpu_q.as ##1 !cpu_q.as |=>
      RAM_A == {$past(cpu_q.hi[`MGB_HI_DIR_MSB:`MGB_HI_DIR_LSB]), $past(cpu_q.ad, 2)};
  endproperty
  a_addr_join: assert property (p_addr_join) else $error("RAM address not upper plus latched byte");

  property p_ce_cause;
    @(posedge CLK) disable iff (RST) !RAM_CE_N |-> $past(cpu_q.hi[`MGB_HI_RAM_BIT]) && $past(cpu_q.e);
  endproperty
  a_ce_cause: assert property (p_ce_cause) else $error("RAM enabled without top bit and strobe");

  property p_ce_low;
    @(posedge CLK) disable iff (RST) (cpu_q.hi[`MGB_HI_RAM_BIT] && cpu_q.e) |=> !RAM_CE_N;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("RAM enable not driven low");

  property p_upper_half;
    @(posedge CLK) disable iff (RST) !cpu_q.hi[`MGB_HI_RAM_BIT] |=> RAM_CE_N && RAM_WE_N && RAM_OE_N;
  endproperty
  a_upper_half: assert property (p_upper_half) else $error("RAM touched in lower half");

  property p_dir;
    @(posedge CLK) disable iff (RST) !RAM_WE_N |-> !$past(cpu_q.rw) && !RAM_CE_N && RAM_OE_N;
  endproperty
  a_dir: assert property (p_dir) else $error("Write strobe with read direction");

  property p_gated;
    @(posedge CLK) disable iff (RST) RAM_CE_N |-> RAM_WE_N && RAM_OE_N && !RAM_DQ_OE;
  endproperty
  a_gated: assert property (p_gated) else $error("RAM strobe while disabled");

  property p_no_fight;
    @(posedge CLK) disable iff (RST) !(AD_OE && RAM_DQ_OE);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("Both ends drive the data lines");

  property p_wr_data;
    @(posedge CLK) disable iff (RST) RAM_DQ_OE |-> RAM_DQ_O == $past(cpu_q.ad);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("RAM write data not from shared lines");

  property p_port_rd;
    @(posedge CLK) disable iff (RST)
      (cpu_q.hi[`MGB_HI_PAGE_MSB:`MGB_HI_PAGE_LSB] == `MGB_IO_PAGE && cpu_q.e && cpu_q.rw) |=>
      AD_OE && AD_O == $past(in_q);
  endproperty
  a_port_rd: assert property (p_port_rd) else $error("Port read did not return input latch");

  property p_port_wr;
    @(posedge CLK) disable iff (RST)
      (cpu_q.hi[`MGB_HI_PAGE_MSB:`MGB_HI_PAGE_LSB] == `MGB_IO_PAGE && cpu_q.e && !cpu_q.rw) |=>
      OUT_PORT == $past(cpu_q.ad);
  endproperty
  a_port_wr: assert property (p_port_wr) else $error("Port write did not load output latch");

  property p_ram_rd;
    @(posedge CLK) disable iff (RST)
      (cpu_q.hi[`MGB_HI_RAM_BIT] && cpu_q.e && cpu_q.rw) |=> AD_OE && AD_O == $past(ram_q);
  endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("RAM read did not return memory data");

endmodule : mgb_glue

/* File: mgb_cpu_model.sv */
// Processor model that runs multiplexed bus cycles against the glue
`timescale 1ns/1ps
module mgb_cpu_model (
  // Clock
  input  wire logic       clk,
  // Bus
  output logic            as,
  output logic            e,
  output logic            rw,
  output logic      [7:0] a_hi,
  output logic      [7:0] ad,
  input  wire logic [7:0] ad_in
);
  // Idle bus at time zero
  initial begin
    as   = 0;
    e    = 0;
    rw   = 1;
    a_hi = 8'h00;
    ad   = 8'h00;
  end

  task automatic cycle(input logic [15:0] a, input logic rd, input logic [7:0] wd, output logic [7:0] q);
    @(posedge clk) #1;
    as   = 1;
    rw   = rd;
    a_hi = a[15:8];
    ad   = a[7:0];
    repeat (6) @(posedge clk);
    #1 as = 0;
    ad = rd ? ~ad : wd; // Released lines show the inverse on a read
    e  = 1;
    repeat (12) @(posedge clk);
    q = ad_in;
    #1 e = 0;
    repeat (6) @(posedge clk);
  endtask : cycle
endmodule : mgb_cpu_model

/* File: test_mgb_glue.sv */
// Self-checking bench for the bus glue
`timescale 1ns/1ps
module test_mgb_glue;
  import mgb_pkg::*;
  logic        CLK = 0, RST = 1, AS, E, RW, AD_OE, RAM_DQ_OE, RAM_CE_N, RAM_OE_N, RAM_WE_N;
  logic [7:0]  A_HI, AD_I, AD_O, RAM_DQ_I, RAM_DQ_O, IN_PORT = 8'h00, OUT_PORT, cpu_ad, q;
  logic [14:0] RAM_A;
  logic [7:0]  mem [0:32767];
  int          n_errors = 0, samples_checked = 0, cyc = 0, ce_cnt = 0;

  // Clock, shared data lines and RAM
  initial forever #12.5 CLK = ~CLK;
  assign AD_I     = AD_OE ? AD_O : cpu_ad;
  assign RAM_DQ_I = (!RAM_CE_N && !RAM_OE_N) ? mem[RAM_A] : cyc[7:0];

  mgb_cpu_model u_cpu (.clk(CLK), .as(AS), .e(E), .rw(RW), .a_hi(A_HI), .ad(cpu_ad), .ad_in(AD_I));
  mgb_glue u_dut (.CLK(CLK), .RST(RST), .AS(AS), .E(E), .RW(RW), .A_HI(A_HI), .AD_I(AD_I), .AD_O(AD_O),
    .AD_OE(AD_OE), .RAM_A(RAM_A), .RAM_DQ_I(RAM_DQ_I), .RAM_DQ_O(RAM_DQ_O), .RAM_DQ_OE(RAM_DQ_OE),
    .RAM_CE_N(RAM_CE_N), .RAM_OE_N(RAM_OE_N), .RAM_WE_N(RAM_WE_N), .IN_PORT(IN_PORT), .OUT_PORT(OUT_PORT));

  // RAM writes, enable monitor and hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (!RAM_CE_N && !RAM_WE_N) mem[RAM_A] <= RAM_DQ_O;
    if (!RAM_CE_N) ce_cnt <= ce_cnt + 1;
    if (cyc > 4000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic t_reset();
    check({RAM_CE_N, RAM_OE_N, RAM_WE_N}, 3'b111, "strobes idle");
    check({AD_OE, RAM_DQ_OE}, 2'b00, "drivers off");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ram();
    logic [15:0] a [4] = '{16'h8123, 16'h8223, 16'hffff, 16'h8000};
    logic [7:0]  d [4] = '{8'h55, 8'haa, 8'h0f, 8'hf0};
    foreach (a[i]) u_cpu.cycle(a[i], 0, d[i], q);
    foreach (a[i]) begin
      u_cpu.cycle(a[i], 1, 8'h00, q);
      check(q, d[i], "ram readback");
    end
    check(mem[15'h0123], 8'h55, "ram location");
    $display("t_ram done");
  endtask : t_ram

  task automatic t_low();
    int c0;
    @(posedge CLK) #1 c0 = ce_cnt;
    u_cpu.cycle(16'h0123, 0, 8'h99, q);
    u_cpu.cycle(16'h4123, 1, 8'h00, q);
    check(16'(ce_cnt - c0), 16'h0000, "ram enabled outside upper half");
    u_cpu.cycle(16'h8123, 1, 8'h00, q);
    check(q, 8'h55, "ram overwritten");
    $display("t_low done");
  endtask : t_low

  task automatic t_port();
    int c0;
    @(posedge CLK) #1 c0 = ce_cnt;
    IN_PORT = 8'hc3;
    u_cpu.cycle(16'h7abc, 0, 8'h3c, q);
    check(OUT_PORT, 8'h3c, "output latch");
    u_cpu.cycle(16'h7123, 1, 8'h00, q);
    check(q, 8'hc3, "input latch");
    check(16'(ce_cnt - c0), 16'h0000, "ram enabled on port");
    $display("t_port done");
  endtask : t_port

  // Main sequence
  initial begin
    repeat (8) @(posedge CLK);
    #1;
    t_reset();
    RST = 0;
    repeat (3) @(posedge CLK);
    t_ram();
    t_low();
    t_port();
    wrap_up();
  end
endmodule : test_mgb_glue
